// ---- pll_out_consts.svh ----
`ifndef PLL_OUT_CONSTS_SVH
`define PLL_OUT_CONSTS_SVH
// Behaviour
// - top two divider-word bits pick output: 11 ref pulse, 10 feedback, 01 data, 00 port
// - reference divider counts low 13 reference-word bits, 5..8191, output pulses high
// - reference ratio 1 passes reference input straight to the detectors
// - feedback divides VCO input by N*64+A with prescaler, swallow and 12-stage counter
// - data-out mode shows shift register end, updated on serial clock falling edge
// - after reset the configurable output shows serial data out
// - port mode drives configurable output to the expander level bit
// - open-drain output pulls low when its bit is 0, floats when 1
// - reset leaves the open-drain output pulling low
// - reference mode 001 runs the oscillator with the reference divider counting
// - crystal mode in standby keeps oscillator running, reference divider halted
// - reference mode 0 stops the oscillator, standby or not
// - reference mode 7 gives reference input divided by 16 on reference output
// - reference mode 3 gives reference output equal to reference input
// - after reset the reference output divides by eight
// - reference mode 2 keeps reference input working, reference output held off
// - single-ended detector sinks when feedback leads, sources when lags; invert swaps
// - single-ended detector floats when deselected or in standby
// - double-ended: feedback side low when leading, reference side when lagging; invert swaps
// - double-ended outputs held high when deselected or in standby
// - lock indicator is AND of both double-ended outputs
// - after reset the lock indicator is held low
// - lock enable bit 0 holds lock indicator low, 1 lets it run
// - detector select 1 picks single-ended, 0 double-ended; cleared at reset
// - words commit on enable rising edge by bit count: 8, 16 or 24

// serial word lengths
`define LEN_CFG 6'd8
`define LEN_REF 6'd16
`define LEN_DIV 6'd24
`define LEN_MAX 6'h3F

// divider word fields
`define DIV_SEL_HI 23
`define DIV_SEL_LO 22
`define DIV_N_HI 17
`define DIV_N_LO 6
`define DIV_A_HI 5
`define DIV_A_LO 0
`define SEL_REF 2'b11
`define SEL_FB 2'b10
`define SEL_DATA 2'b01
`define SEL_PORT 2'b00

// reference word fields
`define REF_MODE_HI 15
`define REF_MODE_LO 13
`define REF_RATIO_HI 12
`define REF_RATIO_LO 0
`define MODE_OFF 3'h0
`define MODE_XTAL 3'h1
`define MODE_NOOUT 3'h2
`define MODE_DIV1 3'h3
`define MODE_DIV2 3'h4
`define MODE_DIV4 3'h5
`define MODE_DIV8 3'h6
`define MODE_DIV16 3'h7

// reset values
`define RST_CFG 8'h00
`define RST_REF 16'hC000
`define RST_DIV 24'h40_0000

// prescaler reloads (count-1 for divide by 64 and 65)
`define PRE_64 6'h3F
`define PRE_65 7'h40

// register word indices on the bus
`define ADDR_CFG 3'h0
`define ADDR_REF 3'h1
`define ADDR_DIV 3'h2
`define ADDR_STAT 3'h3
`define ADDR_SHIFT 3'h4

`endif

// ---- pll_out_pkg.sv ----
package pll_out_pkg;
    typedef struct packed {
        logic invert_sense_bit;
        logic detector_select_bit;
        logic lock_enable_bit;
        logic sleep_bit;
        logic [1:0] current_bits;
        logic expander_level_bit;
        logic open_drain_level_bit;
    } cfg_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [2:0] address;
        logic [31:0] writedata;
    } avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avs_rsp_t;
endpackage : pll_out_pkg

// ---- pll_output_mux_phase_detect.sv ----
`include "pll_out_consts.svh"

module pll_output_mux_phase_detect #(
    parameter int REF_CNT_W = 13,
    parameter int FB_MAIN_W = 12,
    parameter int SWALLOW_W = 6
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // serial programming port
    input wire logic SER_CLK,
    input wire logic SER_DIN,
    input wire logic SER_EN_N,
    // frequency inputs
    input wire logic REFERENCE_INPUT_PIN,
    input wire logic VCO_IN,
    // register bus
    input wire pll_out_pkg::avs_req_t AVS_REQ,
    output pll_out_pkg::avs_rsp_t AVS_RSP,
    // digital outputs
    output logic CFG_OUT,
    output logic OPEN_DRAIN_O,
    output logic OPEN_DRAIN_OE,
    output logic REFERENCE_OUTPUT_PIN,
    // detectors
    output logic SINGLE_ENDED_DETECTOR_OUT_O,
    output logic SINGLE_ENDED_DETECTOR_OUT_OE,
    output logic PHI_REF_N,
    output logic PHI_FB_N,
    output logic LOCK_INDICATOR
);
    import pll_out_pkg::*;

    if (REF_CNT_W != 13 || FB_MAIN_W != 12 || SWALLOW_W != 6) begin : g_chk
        $error("divider widths must match the word layout");
    end

    // committed words
    cfg_t cfg_q;
    logic [15:0] ref_word_q;
    logic [REF_CNT_W-1:0] ref_ratio_q;
    logic [23:0] div_word_q;

    // serial shifter
    logic sclk_q;
    logic sen_n_q;
    logic [23:0] shift_q;
    logic [5:0] bit_cnt_q;
    logic dout_q;

    wire sclk_rise = SER_CLK & ~sclk_q;
    wire sclk_fall = ~SER_CLK & sclk_q;
    wire shifting = ~SER_EN_N;
    wire commit = SER_EN_N & ~sen_n_q;
    wire commit_cfg = commit && bit_cnt_q == `LEN_CFG;
    wire commit_ref = commit && bit_cnt_q == `LEN_REF;
    wire commit_div = commit && bit_cnt_q == `LEN_DIV;
    // enable pulse with no clocks moves the first reference buffer on
    wire commit_xfer = commit && bit_cnt_q == 6'h00;

    // serial pins are sampled, so each level must last two clocks
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            sclk_q <= 1'b0;
            sen_n_q <= 1'b1;
        end else begin
            sclk_q <= SER_CLK;
            sen_n_q <= SER_EN_N;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST || !shifting) begin
            bit_cnt_q <= 6'h00;
        end else if (sclk_rise && bit_cnt_q != `LEN_MAX) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            shift_q <= 24'h00_0000;
            dout_q <= 1'b0;
        end else if (shifting) begin
            if (sclk_rise) begin
                shift_q <= {shift_q[22:0], SER_DIN};
            end
            if (sclk_fall) begin
                dout_q <= shift_q[23];
            end
        end
    end

    // bus writes load words directly; a serial commit in the same cycle wins
    wire bus_wr = AVS_REQ.write;
    wire bus_wr_cfg = bus_wr && AVS_REQ.address == `ADDR_CFG;
    wire bus_wr_ref = bus_wr && AVS_REQ.address == `ADDR_REF;
    wire bus_wr_div = bus_wr && AVS_REQ.address == `ADDR_DIV;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cfg_q <= cfg_t'(`RST_CFG);
            ref_word_q <= `RST_REF;
            // ratio buffer starts empty: no reference pulses until a ratio is loaded
            ref_ratio_q <= REF_CNT_W'(`RST_REF);
            div_word_q <= `RST_DIV;
        end else begin
            if (commit_cfg) begin
                cfg_q <= cfg_t'(shift_q[7:0]);
            end else if (bus_wr_cfg) begin
                cfg_q <= cfg_t'(AVS_REQ.writedata[7:0]);
            end
            if (commit_ref) begin
                ref_word_q <= shift_q[15:0];
            end else if (bus_wr_ref) begin
                ref_word_q <= AVS_REQ.writedata[15:0];
            end
            if (commit_div) begin
                div_word_q <= shift_q;
            end else if (bus_wr_div) begin
                div_word_q <= AVS_REQ.writedata[23:0];
            end
            // second reference buffer follows on a serial divider load or a bare enable pulse
            if (commit_div || commit_xfer) begin
                ref_ratio_q <= ref_word_q[`REF_RATIO_HI:`REF_RATIO_LO];
            end else if (bus_wr_ref) begin
                ref_ratio_q <= AVS_REQ.writedata[`REF_RATIO_HI:`REF_RATIO_LO];
            end
        end
    end

    // reference path
    wire [2:0] ref_mode = ref_word_q[`REF_MODE_HI:`REF_MODE_LO];
    wire osc_on = ref_mode != `MODE_OFF;
    logic ref_in_q;
    wire ref_tick = osc_on & REFERENCE_INPUT_PIN & ~ref_in_q;
    wire sleep = cfg_q.sleep_bit;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ref_in_q <= 1'b0;
        end else begin
            ref_in_q <= REFERENCE_INPUT_PIN;
        end
    end

    // reference output divider keeps running in standby
    logic [3:0] refo_cnt_q;
    logic refo_q;
    logic refo_bit;

    always_comb begin
        unique case (ref_mode)
            `MODE_DIV1: refo_bit = ref_in_q;
            `MODE_DIV2: refo_bit = refo_cnt_q[0];
            `MODE_DIV4: refo_bit = refo_cnt_q[1];
            `MODE_DIV8: refo_bit = refo_cnt_q[2];
            `MODE_DIV16: refo_bit = refo_cnt_q[3];
            default: refo_bit = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            refo_cnt_q <= 4'h0;
            refo_q <= 1'b0;
        end else begin
            if (ref_tick) begin
                refo_cnt_q <= refo_cnt_q + 4'h1;
            end
            refo_q <= refo_bit;
        end
    end

    // reference divider halts in standby, oscillator does not
    logic [REF_CNT_W-1:0] ref_cnt_q;
    logic ref_div_pulse;
    wire ref_run = ref_tick & ~sleep;
    wire ref_bypass = ref_ratio_q == 13'h0001;
    // a zero ratio parks the counter, so a new ratio starts at its first tick
    wire ref_cnt_low = ref_cnt_q <= 13'h0001;
    wire ref_div_end = ref_run && ref_cnt_low && ref_ratio_q != 13'h0000;
    wire [REF_CNT_W-1:0] ref_cnt_nx = ref_cnt_low ? ref_ratio_q : ref_cnt_q - 13'h0001;
    wire ref_pulse = ref_bypass ? ref_run : ref_div_end;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ref_cnt_q <= 13'h0000;
            ref_div_pulse <= 1'b0;
        end else begin
            ref_div_pulse <= ref_pulse;
            if (ref_run) begin
                ref_cnt_q <= ref_cnt_nx;
            end
        end
    end

    // feedback path: swallow cycles divide by 65, the rest by 64
    logic [6:0] pre_q;
    logic [SWALLOW_W-1:0] swallow_q;
    logic [FB_MAIN_W-1:0] main_q;
    logic feedback_divider_pulse;
    logic vco_q;
    wire [FB_MAIN_W-1:0] n_val = div_word_q[`DIV_N_HI:`DIV_N_LO];
    wire [SWALLOW_W-1:0] a_val = div_word_q[`DIV_A_HI:`DIV_A_LO];
    wire vco_tick = VCO_IN & ~vco_q & ~sleep;
    wire pre_end = vco_tick && pre_q == 7'h00;
    wire fb_end = pre_end && main_q <= 12'h001 && n_val != 12'h000;
    // swallow counter stops at zero rather than wrapping into extra divide-by-65 cycles
    wire swallow_busy = swallow_q != 6'h00;
    wire [SWALLOW_W-1:0] swallow_nx = fb_end ? a_val : (swallow_busy ? swallow_q - 6'h01 : 6'h00);
    // empty main counter waits at zero so a newly written N acts at once
    wire [FB_MAIN_W-1:0] main_nx = (main_q <= 12'h001) ? n_val : main_q - 12'h001;
    wire [6:0] pre_load = swallow_nx != 6'h00 ? `PRE_65 : {1'b0, `PRE_64};

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            vco_q <= 1'b0;
            pre_q <= {1'b0, `PRE_64};
            swallow_q <= 6'h00;
            main_q <= 12'h000;
            feedback_divider_pulse <= 1'b0;
        end else begin
            vco_q <= VCO_IN;
            feedback_divider_pulse <= fb_end;
            if (pre_end) begin
                pre_q <= pre_load;
                main_q <= main_nx;
                if (swallow_q != 6'h00 || fb_end) begin
                    swallow_q <= swallow_nx;
                end
            end else if (vco_tick) begin
                pre_q <= pre_q - 7'h01;
            end
        end
    end

    // phase/frequency detector core; both set means matched, cleared next cycle
    // standby clears it, so leaving standby starts from a clean detector
    logic up_q;
    logic dn_q;
    wire both = up_q & dn_q;

    always_ff @(posedge REF_CLK) begin
        if (SRST || sleep) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else if (both) begin
            up_q <= ref_div_pulse;
            dn_q <= feedback_divider_pulse;
        end else begin
            up_q <= up_q | ref_div_pulse;
            dn_q <= dn_q | feedback_divider_pulse;
        end
    end

    wire se_on = cfg_q.detector_select_bit & ~sleep;
    wire de_on = ~cfg_q.detector_select_bit & ~sleep;
    wire lead = cfg_q.invert_sense_bit ? up_q : dn_q;
    wire lag = cfg_q.invert_sense_bit ? dn_q : up_q;
    logic se_o_q;
    logic se_oe_q;
    logic phi_ref_n_q;
    logic phi_fb_n_q;
    logic lock_q;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            se_o_q <= 1'b0;
            se_oe_q <= 1'b0;
            phi_ref_n_q <= 1'b1;
            phi_fb_n_q <= 1'b1;
            lock_q <= 1'b0;
        end else begin
            se_oe_q <= se_on & (lead ^ lag);
            se_o_q <= lag & ~lead;
            phi_fb_n_q <= ~(de_on & lead);
            phi_ref_n_q <= ~(de_on & lag);
            lock_q <= cfg_q.lock_enable_bit & ~(de_on & (lead | lag));
        end
    end

    // configurable output select
    logic cfg_out_q;
    wire [1:0] out_sel = {div_word_q[`DIV_SEL_HI], div_word_q[`DIV_SEL_LO]};

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cfg_out_q <= 1'b0;
        end else begin
            unique case (out_sel)
                `SEL_REF: cfg_out_q <= ref_div_pulse;
                `SEL_FB: cfg_out_q <= feedback_divider_pulse;
                `SEL_DATA: cfg_out_q <= dout_q;
                `SEL_PORT: cfg_out_q <= cfg_q.expander_level_bit;
            endcase
        end
    end

    // bus slave: writes take no wait, reads wait one cycle for registered data
    logic rd_done_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    wire [31:0] stat_word = {26'h000_0000, LOCK_INDICATOR, PHI_FB_N, PHI_REF_N,
                             SINGLE_ENDED_DETECTOR_OUT_OE, OPEN_DRAIN_OE, CFG_OUT};

    always_comb begin
        unique case (AVS_REQ.address)
            `ADDR_CFG: rdata_d = {24'h00_0000, cfg_q};
            `ADDR_REF: rdata_d = {16'h0000, ref_word_q};
            `ADDR_DIV: rdata_d = {8'h00, div_word_q};
            `ADDR_STAT: rdata_d = stat_word;
            `ADDR_SHIFT: rdata_d = {2'b00, bit_cnt_q, shift_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rd_done_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rd_done_q <= AVS_REQ.read & ~rd_done_q;
            if (AVS_REQ.read & ~rd_done_q) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign AVS_RSP.waitrequest = AVS_REQ.read & ~rd_done_q;
    assign AVS_RSP.readdata = rdata_q;

    // pins
    assign CFG_OUT = cfg_out_q;
    // the open-drain pin only sinks; its enable carries the level
    assign OPEN_DRAIN_O = 1'b0;
    assign OPEN_DRAIN_OE = ~cfg_q.open_drain_level_bit;
    assign REFERENCE_OUTPUT_PIN = refo_q;
    assign SINGLE_ENDED_DETECTOR_OUT_O = se_o_q;
    assign SINGLE_ENDED_DETECTOR_OUT_OE = se_oe_q;
    assign PHI_REF_N = phi_ref_n_q;
    assign PHI_FB_N = phi_fb_n_q;
    assign LOCK_INDICATOR = lock_q;
endmodule : pll_output_mux_phase_detect

// ---- pll_out_checker.sv ----
module pll_out_checker (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // watched pins
    input wire logic SER_EN_N,
    input wire pll_out_pkg::avs_req_t AVS_REQ,
    input wire pll_out_pkg::avs_rsp_t AVS_RSP,
    input wire logic CFG_OUT,
    input wire logic OPEN_DRAIN_O,
    input wire logic OPEN_DRAIN_OE,
    input wire logic REFERENCE_OUTPUT_PIN,
    input wire logic SINGLE_ENDED_DETECTOR_OUT_OE,
    input wire logic PHI_REF_N,
    input wire logic PHI_FB_N,
    input wire logic LOCK_INDICATOR
);
    timeunit 1ns;
    timeprecision 1ns;
    import pll_out_pkg::*;
    default clocking cb @(posedge REF_CLK);
    endclocking
    wire phi_low = !PHI_REF_N || !PHI_FB_N;
    sequence s_read_wait;
        AVS_RSP.waitrequest ##1 !AVS_RSP.waitrequest;
    endsequence
    // two quiet cycles let any earlier commit land first
    sequence s_shift_quiet;
        !SER_EN_N && !AVS_REQ.write ##1 !SER_EN_N && !AVS_REQ.write;
    endsequence
    a_reset_state:
        assert property (SRST |=> OPEN_DRAIN_OE && !LOCK_INDICATOR && PHI_REF_N && PHI_FB_N
            && !SINGLE_ENDED_DETECTOR_OUT_OE) else $error("bad reset state");
    a_release_state:
        assert property ($fell(SRST) |-> !CFG_OUT && !REFERENCE_OUTPUT_PIN)
        else $error("bad release state");
    a_drain_low_only:
        assert property (disable iff (SRST) !OPEN_DRAIN_O) else $error("drain driven high");
    a_lock_needs_phi:
        assert property (disable iff (SRST) phi_low |-> ##[0:1] !LOCK_INDICATOR)
        else $error("lock high with phase low");
    a_detector_split:
        assert property (disable iff (SRST) !(SINGLE_ENDED_DETECTOR_OUT_OE && phi_low))
        else $error("both detectors active");
    a_read_one_wait:
        assert property (disable iff (SRST) $rose(AVS_REQ.read) |-> s_read_wait)
        else $error("read wait wrong");
    a_write_no_wait:
        assert property (disable iff (SRST) AVS_REQ.write |-> !AVS_RSP.waitrequest)
        else $error("write stalled");
    a_shift_holds_drain:
        assert property (disable iff (SRST) s_shift_quiet |=> $stable(OPEN_DRAIN_OE))
        else $error("drain moved while shifting");
endmodule : pll_out_checker

bind pll_output_mux_phase_detect pll_out_checker u_checker (
    .REF_CLK(REF_CLK), .SRST(SRST), .SER_EN_N(SER_EN_N), .AVS_REQ(AVS_REQ), .AVS_RSP(AVS_RSP),
    .CFG_OUT(CFG_OUT), .OPEN_DRAIN_O(OPEN_DRAIN_O), .OPEN_DRAIN_OE(OPEN_DRAIN_OE),
    .REFERENCE_OUTPUT_PIN(REFERENCE_OUTPUT_PIN),
    .SINGLE_ENDED_DETECTOR_OUT_OE(SINGLE_ENDED_DETECTOR_OUT_OE),
    .PHI_REF_N(PHI_REF_N), .PHI_FB_N(PHI_FB_N), .LOCK_INDICATOR(LOCK_INDICATOR)
);

// ---- serial_host.sv ----
module serial_host (
    // clock
    input wire logic clk,
    // serial pins
    output logic ser_clk,
    output logic ser_din,
    output logic ser_en_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ser_clk = 1'b0;
        ser_din = 1'b0;
        ser_en_n = 1'b1;
    end
    // two cycles per level so the sampler never misses an edge
    task automatic hold(input logic c);
        ser_clk <= c;
        repeat (2) @(posedge clk);
    endtask : hold
    // msb first; a count of 0 only pulses the enable
    task automatic send(input logic [23:0] w, input int n);
        ser_en_n <= 1'b0;
        hold(1'b0);
        for (int i = n - 1; i >= 0; i--) begin
            ser_din <= w[i];
            hold(1'b0);
            hold(1'b1);
        end
        hold(1'b0);
        ser_en_n <= 1'b1;
        // released line must not keep the last bit
        ser_din <= ~ser_din;
        repeat (4) @(posedge clk);
    endtask : send
endmodule : serial_host

// ---- pll_output_mux_phase_detect_bench.sv ----
module pll_output_mux_phase_detect_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import pll_out_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic vco = 1'b0;
    logic [1:0] rdiv = 2'h0;
    avs_req_t req = '0;
    avs_rsp_t rsp;
    logic ser_clk, ser_din, ser_en_n;
    logic cfg_out, od_oe, ref_out, se_o, se_oe, phi_r, phi_f, lock;
    logic [31:0] exp_q[$];
    logic [1:0] v;
    logic [7:0] cf[4] = '{8'h20, 8'hA0, 8'h40, 8'hC0};
    logic [2:0] md[6] = '{3'h7, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    int ro[6] = '{20, 320, 0, 40, 160, 80};
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_pulse, n_rout, n_fb, n_rf, n_sink, n_src, n_lock;
    wire ref_in = rdiv[1];

    initial forever #20 clk = ~clk;
    // reference at a quarter of the clock keeps every output ratio legal
    always @(posedge clk) rdiv <= rdiv + 2'h1;
    always @(posedge clk) vco <= ~vco;

    serial_host host (.clk(clk), .ser_clk(ser_clk), .ser_din(ser_din), .ser_en_n(ser_en_n));
    pll_output_mux_phase_detect DUT (
        .REF_CLK(clk), .SRST(srst), .SER_CLK(ser_clk), .SER_DIN(ser_din),
        .SER_EN_N(ser_en_n), .REFERENCE_INPUT_PIN(ref_in), .VCO_IN(vco),
        .AVS_REQ(req), .AVS_RSP(rsp), .CFG_OUT(cfg_out), .OPEN_DRAIN_O(),
        .OPEN_DRAIN_OE(od_oe), .REFERENCE_OUTPUT_PIN(ref_out),
        .SINGLE_ENDED_DETECTOR_OUT_O(se_o), .SINGLE_ENDED_DETECTOR_OUT_OE(se_oe),
        .PHI_REF_N(phi_r), .PHI_FB_N(phi_f), .LOCK_INDICATOR(lock)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check

    // pulse counts depend on divider phase, so one count either way is allowed
    task automatic near(input int got, input int want);
        check(32'(got >= want - 1 && got <= want + 1), 32'h0000_0001);
    endtask : near

    task automatic conclude;
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic bus(input logic rd, input logic [2:0] a, input logic [31:0] d);
        if (rd) begin
            exp_q.push_back(d);
        end
        req <= '{rd, !rd, a, rd ? 32'h0 : d};
        @(posedge clk iff !rsp.waitrequest);
        req <= '0;
        @(posedge clk);
    endtask : bus

    task automatic watch;
        logic lc, lr;
        {n_pulse, n_rout, n_fb, n_rf, n_sink, n_src, n_lock} = '0;
        // let a just-written setting settle before counting
        repeat (4) @(posedge clk);
        lc = cfg_out;
        lr = ref_out;
        repeat (1280) begin
            @(posedge clk);
            n_pulse += int'(cfg_out && !lc);
            n_rout += int'(ref_out && !lr);
            n_fb += int'(!phi_f);
            n_rf += int'(!phi_r);
            n_sink += int'(se_oe && !se_o);
            n_src += int'(se_oe && se_o);
            n_lock += int'(lock === 1'b1);
            lc = cfg_out;
            lr = ref_out;
        end
    endtask : watch

    always @(posedge clk) begin
        if (req.read && !rsp.waitrequest) begin
            check(rsp.readdata, exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        void'($urandom(3));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(1, 3'h0, 32'h0);
        bus(1, 3'h1, 32'h0000_C000);
        bus(1, 3'h2, 32'h0040_0000);
        bus(1, 3'h3, 32'h0000_001A);
        bus(1, 3'h5, 32'h0);
        host.send(24'h70_0000, 24);
        host.send(24'h00_0000, 2);
        bus(1, 3'h2, 32'h0070_0000);
        bus(1, 3'h3, 32'h0000_001B);
        bus(1, 3'h4, 32'h00C0_0000);
        host.send(24'h00_0000, 24);
        repeat (4) begin
            v = 2'($urandom);
            host.send({22'h0, v}, 8);
            bus(1, 3'h0, {30'h0, v});
            bus(1, 3'h3, {26'h0, 4'h6, ~v[0], v[1]});
        end
        host.send(24'h00_2005, 16);
        host.send(24'h00_0000, 0);
        bus(0, 3'h2, 32'h00C0_0000);
        watch();
        near(n_pulse, 64);
        bus(1, 3'h1, 32'h0000_2005);
        bus(0, 3'h1, 32'h0000_2001);
        watch();
        near(n_pulse, 320);
        bus(0, 3'h0, 32'h0000_0010);
        watch();
        check(32'(n_pulse + n_rf + n_fb), 32'h0);
        bus(0, 3'h0, 32'h0000_0050);
        watch();
        check(32'(n_pulse + n_sink + n_src), 32'h0);
        bus(0, 3'h0, 32'h0);
        bus(0, 3'h1, 32'h0000_0005);
        watch();
        check(32'(n_pulse + n_rout), 32'h0);
        foreach (md[i]) begin
            bus(0, 3'h1, {16'h0, md[i], 13'h0005});
            watch();
            near(n_rout, ro[i]);
        end
        // N of 1 and A of 1: a 65-tick period, N not below A
        bus(0, 3'h2, 32'h0080_0041);
        watch();
        near(n_pulse, 10);
        // reference faster than feedback, so the loop always lags
        bus(0, 3'h1, 32'h0000_2005);
        foreach (cf[i]) begin
            bus(0, 3'h0, {24'h0, cf[i]});
            watch();
            check(32'(cf[i][6] ? n_src > n_sink : n_rf > n_fb), 32'(!cf[i][7]));
            check(32'(cf[i][6] ? n_rf + n_fb : n_sink + n_src), 32'h0);
            check(32'(n_lock > 0), 32'(cf[i][5]));
        end
        conclude();
    end
endmodule : pll_output_mux_phase_detect_bench
